// ---- src/dpl_fifo.sv ----
// Flip-flop FIFO with valid/ready on both sides
module dpl_fifo #(
  parameter int W     = 22,
  parameter int DEPTH = 16
) (
  input wire logic    clk,
  input wire logic    rst,
  dpl_stream_if.snk   wr,
  dpl_stream_if.src   rd
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem_q [DEPTH];  // Storage
  logic [W-1:0] mem_d [DEPTH];
  logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;  // Pointers
  logic [AW:0]   cnt_q, cnt_d;           // Fill level
  logic          push, pop;

  // Pointer and storage update
  always_comb begin
    push = wr.valid & wr.ready;
    pop  = rd.valid & rd.ready;
    mem_d = mem_q;
    wp_d  = wp_q;
    rp_d  = rp_q;
    if (push) begin
      mem_d[wp_q] = wr.data;
      wp_d = (wp_q == AW'(DEPTH - 1)) ? '0 : wp_q + 1'b1;
    end
    if (pop) begin
      rp_d = (rp_q == AW'(DEPTH - 1)) ? '0 : rp_q + 1'b1;
    end
    cnt_d = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  end

  // Register state
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
      for (int i = 0; i < DEPTH; i++) mem_q[i] <= '0;
    end else begin
      wp_q  <= wp_d;
      rp_q  <= rp_d;
      cnt_q <= cnt_d;
      mem_q <= mem_d;
    end
  end

  // Honest full and empty
  assign wr.ready = (cnt_q != (AW+1)'(DEPTH));
  assign rd.valid = (cnt_q != '0);
  assign rd.data  = mem_q[rp_q];

  full_refuse_a: assert property (@(posedge clk) disable iff (rst)
    cnt_q == (AW+1)'(DEPTH) |-> !wr.ready ##1 (cnt_q == (AW+1)'(DEPTH) || $past(pop)))
    else $error("write taken while full");
  fifo_full_c: cover property (@(posedge clk) disable iff (rst) cnt_q == (AW+1)'(DEPTH));
endmodule : dpl_fifo

// ---- src/dpl_mode_ctrl.sv ----
// Dual receive port input mode control and stream packer
// Functional notes
// - Each port set alone: packetized or raw
// - Mode from config field, strap gives start
// - Packetized mode parses 40-bit link frames
// - Raw mode uses 28-bit frames, lower rate
// - Packetized ports remap virtual channel ids
// - Sync clocking: 160x line, 4x pclk, 2x
// - Non-sync: 80x line, pclk 2x/1x, 10M
// - Up to 4.16G line, independent of output
// - Raw pixels get per-port channel and type
// - Raw8 on ten bits, msb or lsb aligned
// - Separate syncs delimit lines and frames
// - Raw12 high band: 12+2 bits, 37.5-100M
// - Raw10: 10+2 bits, 50-100M pixel clock
// - Raw12 low band: 12+2 bits, 25-50M
// - Luma-chroma treated as matching raw width
// - Formats pass unchanged, all packet kinds
// - One four-lane or two replicated outputs
// - Ports interleave, distinct channel per stream
// - Wait 1 ms after power-up before strap
// - Strap selects one of five modes
module dpl_mode_ctrl #(
  parameter int STRAP_WAIT_CYC = dpl_pkg::STRAP_WAIT_CYC
) (
  input  wire logic                                              ref_clk,
  input  wire logic                                              sys_rst,
  input  wire logic                                              power_down_n_pin,
  input  wire logic [2:0]                                        mode_strap,
  input  wire logic [dpl_pkg::NPORT-1:0]                         link_pixel_clock,
  input  wire logic [dpl_pkg::NPORT-1:0]                         pix_hsync,
  input  wire logic [dpl_pkg::NPORT-1:0]                         pix_vsync,
  input  wire logic [dpl_pkg::NPORT-1:0][dpl_pkg::PIX_W-1:0]     pix_data,
  input  wire logic [dpl_pkg::NPORT-1:0]                         pk_valid,
  input  wire logic [dpl_pkg::NPORT-1:0][dpl_pkg::PKT_FRAME_W-1:0] pk_frame,
  output logic      [dpl_pkg::NPORT-1:0]                         pk_ready,
  input  wire logic                                              reg_wr,
  input  wire logic                                              reg_rd,
  input  wire logic                                              reg_port,
  input  wire logic [7:0]                                        reg_addr,
  input  wire logic [7:0]                                        reg_wdata,
  output logic      [7:0]                                        reg_rdata,
  input  wire logic                                              out_ready,
  output logic                                                   out_valid,
  output logic      [dpl_pkg::WORD_W-1:0]                        out_word,
  output logic                                                   clk_sync_mode,
  output logic      [7:0]                                        line_mult,
  output logic      [dpl_pkg::NPORT-1:0][2:0]                    pclk_mult,
  output logic      [1:0]                                        out_lanes,
  output logic                                                   out_replicate
);
  import dpl_pkg::*;

  // ==========================================
  // Strap sampling after power-up
  logic [3:0]  st_lvl;                  // {strap, power good}
  logic [31:0] wait_cnt_q, wait_cnt_d;  // Settle counter
  logic        strap_done_q, strap_done_d;
  logic [2:0]  strap_q, strap_d;        // Captured strap
  logic        clk_sync_q, clk_sync_d;  // Synchronous clocking
  logic        strap_load;              // Apply strap pulse

  dpl_pin_sync #(.W(4)) u_strap_sync (
    .clk  (ref_clk),
    .rst  (sys_rst),
    .din  ({mode_strap, power_down_n_pin}),
    .lvl  (st_lvl),
    .rise (),
    .fall ()
  );

  // Count settle time, then capture the strap once per power-good period
  always_comb begin
    wait_cnt_d   = wait_cnt_q;
    strap_done_d = strap_done_q;
    strap_d      = strap_q;
    clk_sync_d   = clk_sync_q;
    strap_load   = 1'b0;
    if (!st_lvl[0]) begin
      wait_cnt_d   = '0;
      strap_done_d = 1'b0;
    end else if (!strap_done_q) begin
      if (wait_cnt_q == 32'(STRAP_WAIT_CYC - 1)) begin
        strap_load   = 1'b1;
        strap_done_d = 1'b1;
        strap_d      = st_lvl[3:1];
        clk_sync_d   = (st_lvl[3:1] == STRAP_SYNC_PKT);
      end else begin
        wait_cnt_d = wait_cnt_q + 32'h1;
      end
    end
  end

  // Register strap state
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wait_cnt_q   <= '0;
      strap_done_q <= 1'b0;
      strap_q      <= '0;
      clk_sync_q   <= 1'b0;
    end else begin
      wait_cnt_q   <= wait_cnt_d;
      strap_done_q <= strap_done_d;
      strap_q      <= strap_d;
      clk_sync_q   <= clk_sync_d;
    end
  end

  // ==========================================
  // Per-port receive logic
  logic [NPORT-1:0]             hold_vld;   // Word waiting
  logic [WORD_W-1:0]            hold_word [NPORT];
  logic [NPORT-1:0]             grant;      // Drained this cycle
  logic [7:0]                   port_rd [NPORT][4];  // Readback

  for (genvar g = 0; g < NPORT; g++) begin : gen_port
    logic [2:0]        ctl_lvl, ctl_rise;  // {vs, hs, pclk}
    logic [PIX_W-1:0]  pix_lvl;            // Pixel bits
    logic [7:0]        cfg_q, cfg_d;       // Port config
    logic [5:0]        dt_q, dt_d;         // Raw data type
    logic [7:0]        remap_q, remap_d;   // Channel map
    logic              ferr_q, ferr_d;     // Bad frame sticky
    logic              ovf_q, ovf_d;       // Overrun sticky
    logic [WORD_W-1:0] hold_q, hold_d;     // Outgoing word
    logic              hv_q, hv_d;
    logic              hs_prev_q, hs_prev_d, vs_prev_q, vs_prev_d;
    logic              rdy_q, rdy_d;       // Frame intake ready
    dpl_mode_t         mode_q, mode_d;     // Applied mode
    dpl_mode_t         mode_cur;
    logic              raw, wr_g, emit, pk_take, ferr_set, ovf_set;
    logic [1:0]        kind, vc_in;
    logic [PIX_W-1:0]  pix_w;

    dpl_pin_sync #(.W(3)) u_ctl_sync (
      .clk  (ref_clk),
      .rst  (sys_rst),
      .din  ({pix_vsync[g], pix_hsync[g], link_pixel_clock[g]}),
      .lvl  (ctl_lvl),
      .rise (ctl_rise),
      .fall ()
    );
    dpl_pin_sync #(.W(PIX_W)) u_pix_sync (
      .clk  (ref_clk),
      .rst  (sys_rst),
      .din  (pix_data[g]),
      .lvl  (pix_lvl),
      .rise (),
      .fall ()
    );

    // Next state of one port; touches no other port
    always_comb begin
      cfg_d     = cfg_q;
      dt_d      = dt_q;
      remap_d   = remap_q;
      hold_d    = hold_q;
      hv_d      = hv_q;
      hs_prev_d = hs_prev_q;
      vs_prev_d = vs_prev_q;
      mode_d    = mode_q;
      emit      = 1'b0;
      pk_take   = 1'b0;
      ferr_set  = 1'b0;
      ovf_set   = 1'b0;
      kind      = KIND_PIX;
      mode_cur  = dpl_mode_t'(cfg_q[1:0]);
      raw       = (mode_cur != MODE_PKT);
      wr_g      = reg_wr && (reg_port == 1'(g));
      vc_in     = pk_frame[g][PF_VC_LSB +: 2];
      if (mode_cur == MODE_RAW10) begin
        if (cfg_q[CFG_RAW8_EN]) begin
          pix_w = cfg_q[CFG_RAW8_MSB] ? {4'h0, pix_lvl[9:2]} : {4'h0, pix_lvl[7:0]};
        end else begin
          pix_w = {2'h0, pix_lvl[9:0]};
        end
      end else begin
        pix_w = pix_lvl;
      end
      if (wr_g && reg_addr == REG_PORT_CFG) cfg_d = reg_wdata;
      if (wr_g && reg_addr == REG_RAW_DT) dt_d = reg_wdata[5:0];
      if (wr_g && reg_addr == REG_VC_REMAP) remap_d = reg_wdata;
      if (strap_load && st_lvl[3:1] <= STRAP_SYNC_PKT) begin
        cfg_d[1:0] = (st_lvl[3:1] == STRAP_SYNC_PKT) ? 2'h0 : st_lvl[2:1];
      end
      if (grant[g]) hv_d = 1'b0;
      if (mode_cur != mode_q) begin
        hv_d      = 1'b0;
        hs_prev_d = 1'b0;
        vs_prev_d = 1'b0;
        mode_d    = mode_cur;
      end else if (raw && ctl_rise[0]) begin
        // sync edges seen at pixel clock; one event per clock, a vs edge wins over an hs edge
        hs_prev_d = ctl_lvl[1];
        vs_prev_d = ctl_lvl[2];
        emit = 1'b1;
        if (ctl_lvl[2] && !vs_prev_q) kind = KIND_FS;
        else if (!ctl_lvl[2] && vs_prev_q) kind = KIND_FE;
        else if (!ctl_lvl[1] && hs_prev_q) kind = KIND_LE;
        else if (!(ctl_lvl[1] && ctl_lvl[2])) emit = 1'b0;
        if (emit && hv_d) begin
          ovf_set = 1'b1;
        end else if (emit) begin
          // programmed channel and type; raw path
          hold_d = {kind, cfg_q[CFG_VC_LSB +: 2], dt_q, (kind == KIND_PIX) ? pix_w : 12'h000};
          hv_d   = 1'b1;
        end
      end else if (!raw && pk_valid[g] && rdy_q) begin
        // parse a 40-bit frame, parity in bit zero
        pk_take = 1'b1;
        if (^pk_frame[g]) begin
          ferr_set = 1'b1;
        end else begin
          // remap; type and data pass unchanged
          hold_d = {pk_frame[g][PF_KIND_LSB +: 2], remap_q[{vc_in, 1'b0} +: 2],
                    pk_frame[g][PF_DT_LSB +: 6], pk_frame[g][PF_DATA_LSB +: PIX_W]};
          hv_d   = 1'b1;
        end
      end
      // intake paced only by own buffer
      rdy_d  = !raw && !hv_d;
      // Set wins over write-one clear
      ferr_d = ferr_set | (ferr_q & ~(wr_g && reg_addr == REG_STATUS && reg_wdata[ST_FERR]));
      ovf_d  = ovf_set | (ovf_q & ~(wr_g && reg_addr == REG_STATUS && reg_wdata[ST_OVF]));
    end

    // Register port state
    always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
        cfg_q     <= CFG_RST;
        dt_q      <= DT_RST;
        remap_q   <= REMAP_RST;
        ferr_q    <= 1'b0;
        ovf_q     <= 1'b0;
        hold_q    <= '0;
        hv_q      <= 1'b0;
        hs_prev_q <= 1'b0;
        vs_prev_q <= 1'b0;
        rdy_q     <= 1'b0;
        mode_q    <= MODE_PKT;
      end else begin
        cfg_q     <= cfg_d;
        dt_q      <= dt_d;
        remap_q   <= remap_d;
        ferr_q    <= ferr_d;
        ovf_q     <= ovf_d;
        hold_q    <= hold_d;
        hv_q      <= hv_d;
        hs_prev_q <= hs_prev_d;
        vs_prev_q <= vs_prev_d;
        rdy_q     <= rdy_d;
        mode_q    <= mode_d;
      end
    end

    assign hold_vld[g]  = hv_q;
    assign hold_word[g] = hold_q;
    assign pk_ready[g]  = rdy_q;
    assign port_rd[g][0] = cfg_q;
    assign port_rd[g][1] = {2'h0, dt_q};
    assign port_rd[g][2] = remap_q;
    assign port_rd[g][3] = {1'b0, strap_q, ovf_q, ferr_q, strap_done_q, clk_sync_q};
  end

  // ==========================================
  // Interleave ports into the buffer
  dpl_stream_if #(.W(WORD_W)) fifo_in ();
  dpl_stream_if #(.W(WORD_W)) fifo_out ();
  logic rr_q, rr_d;  // Last port served
  logic pick;        // Port offered

  always_comb begin
    pick  = hold_vld[~rr_q] ? ~rr_q : rr_q;
    grant = '0;
    if (fifo_in.ready && hold_vld[pick]) grant[pick] = 1'b1;
    fifo_in.valid = |grant;
    fifo_in.data  = hold_word[pick];
    rr_d = (|grant) ? pick : rr_q;
  end

  dpl_fifo #(.W(WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk (ref_clk),
    .rst (sys_rst),
    .wr  (fifo_in),
    .rd  (fifo_out)
  );

  // ==========================================
  // Output stage, registers and rate reporting
  logic              ov_q, ov_d;        // Output valid
  logic [WORD_W-1:0] ow_q, ow_d;        // Output word
  logic [7:0]        rdata_q, rdata_d;  // Read data
  logic [7:0]        ocfg_q, ocfg_d;    // Output lane setup
  logic [7:0]        lmul_q, lmul_d;
  logic [NPORT-1:0][2:0] pmul_q, pmul_d;
  logic [1:0]        lanes_q, lanes_d;

  // Next values of shared registers
  always_comb begin
    fifo_out.ready = !ov_q || out_ready;
    ov_d = ov_q && !out_ready;
    ow_d = ow_q;
    if (fifo_out.valid && fifo_out.ready) begin
      ov_d = 1'b1;
      ow_d = fifo_out.data;
    end
    ocfg_d = (reg_wr && reg_addr == REG_OUT_CFG) ? reg_wdata : ocfg_q;
    // replication limits each copy to two lanes
    lanes_d = (ocfg_q[0] && ocfg_q[2]) ? 2'h1 : ocfg_q[2:1];
    lmul_d = clk_sync_q ? SYNC_LINE_MULT : NSYNC_LINE_MULT;
    for (int p = 0; p < NPORT; p++) begin
      pmul_d[p] = clk_sync_q ? SYNC_PCLK_MULT : (gen_port_cfg6(p) ? 3'h1 : 3'h2);
    end
    rdata_d = rdata_q;
    if (reg_rd) begin
      unique case (reg_addr)
        REG_PORT_CFG: rdata_d = port_rd[reg_port][0];
        REG_RAW_DT:   rdata_d = port_rd[reg_port][1];
        REG_VC_REMAP: rdata_d = port_rd[reg_port][2];
        REG_STATUS:   rdata_d = port_rd[reg_port][3];
        REG_OUT_CFG:  rdata_d = ocfg_q;
        default:      rdata_d = 8'h00;
      endcase
    end
  end

  function automatic logic gen_port_cfg6(input int p);
    return port_rd[p][0][CFG_PCLK1X];
  endfunction : gen_port_cfg6

  // Register shared state
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rr_q    <= 1'b0;
      ov_q    <= 1'b0;
      ow_q    <= '0;
      rdata_q <= 8'h00;
      ocfg_q  <= OUT_CFG_RST;
      lmul_q  <= NSYNC_LINE_MULT;
      pmul_q  <= '0;
      lanes_q <= 2'h3;
    end else begin
      rr_q    <= rr_d;
      ov_q    <= ov_d;
      ow_q    <= ow_d;
      rdata_q <= rdata_d;
      ocfg_q  <= ocfg_d;
      lmul_q  <= lmul_d;
      pmul_q  <= pmul_d;
      lanes_q <= lanes_d;
    end
  end

  assign out_valid     = ov_q;
  assign out_word      = ow_q;
  assign reg_rdata     = rdata_q;
  assign clk_sync_mode = clk_sync_q;
  assign line_mult     = lmul_q;
  assign pclk_mult     = pmul_q;
  assign out_lanes     = lanes_q;
  assign out_replicate = ocfg_q[0];

  // ==========================================
  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  mode_isolation_a: assert property (reg_wr && !reg_port && !strap_load |=> $stable(gen_port[1].cfg_q))
    else $error("port 1 config moved on port 0 write");
  strap_wait_a: assert property ($rose(strap_done_q) |-> $past(wait_cnt_q) == 32'(STRAP_WAIT_CYC - 1))
    else $error("strap taken before settle time");
  strap_sync_a: assert property (strap_load && st_lvl[3:1] == STRAP_SYNC_PKT |=>
    clk_sync_q && gen_port[0].cfg_q[1:0] == 2'h0) else $error("sync strap not applied");
  sync_rate_a: assert property (clk_sync_q |=> lmul_q == SYNC_LINE_MULT && pmul_q[0] == SYNC_PCLK_MULT)
    else $error("sync rate multipliers wrong");
  nsync_rate_a: assert property (!clk_sync_q |=> lmul_q == NSYNC_LINE_MULT)
    else $error("non-sync line multiplier wrong");
  vc_remap_a: assert property (gen_port[0].pk_take && !gen_port[0].ferr_set |=>
    hold_word[0][19:18] == $past(gen_port[0].remap_q[{gen_port[0].vc_in, 1'b0} +: 2])) else $error("remap wrong");
  raw_type_a: assert property (gen_port[1].emit && !gen_port[1].ovf_set |=>
    hold_word[1][17:12] == gen_port[1].dt_q && hold_vld[1]) else $error("raw data type wrong");
  raw8_msb_a: assert property (gen_port[1].emit && gen_port[1].kind == KIND_PIX && !gen_port[1].ovf_set
    && gen_port[1].mode_cur == MODE_RAW10 && gen_port[1].cfg_q[3:2] == 2'h3
    |=> hold_word[1][11:0] == {4'h0, $past(gen_port[1].pix_lvl[9:2])}) else $error("raw8 alignment wrong");
  raw_no_intake_a: assert property (gen_port[1].raw ##1 gen_port[1].raw |-> !pk_ready[1])
    else $error("frame intake open in raw mode");
  out_hold_a: assert property (ov_q && !out_ready |=> ov_q && $stable(ow_q))
    else $error("output word dropped under stall");
  frame_start_c: cover property (gen_port[0].emit && gen_port[0].kind == KIND_FS);
  both_ports_c: cover property (grant[0] ##[1:4] grant[1]);
  strap_done_c: cover property ($rose(strap_done_q));
endmodule : dpl_mode_ctrl

// ---- src/dpl_pin_sync.sv ----
// Three-stage pin synchroniser with agreement filter and edge pulses
module dpl_pin_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] lvl,
  output logic      [W-1:0] rise,
  output logic      [W-1:0] fall
);
  logic [W-1:0] s1_q, s2_q, s3_q;  // Stages
  logic [W-1:0] lvl_q, lvl_d;      // Filtered level
  logic [W-1:0] rise_q, fall_q;    // Edge pulses

  // Level moves only when stages two and three agree
  always_comb begin
    lvl_d = (s3_q & ~(s2_q ^ s3_q)) | (lvl_q & (s2_q ^ s3_q));
  end

  // Stage one feeds stage two only
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1_q   <= '0;
      s2_q   <= '0;
      s3_q   <= '0;
      lvl_q  <= '0;
      rise_q <= '0;
      fall_q <= '0;
    end else begin
      s1_q   <= din;
      s2_q   <= s1_q;
      s3_q   <= s2_q;
      lvl_q  <= lvl_d;
      rise_q <= lvl_d & ~lvl_q;
      fall_q <= ~lvl_d & lvl_q;
    end
  end

  assign lvl  = lvl_q;
  assign rise = rise_q;
  assign fall = fall_q;
endmodule : dpl_pin_sync

// ---- src/dpl_pkg.sv ----
// Shared constants and types for the dual-port link mode control block
package dpl_pkg;
  // ==========================================
  // Sizes
  localparam int NPORT       = 2;   // Receive ports
  localparam int PIX_W       = 12;  // Parallel pixel data bits
  localparam int WORD_W      = 22;  // {kind, vc, dt, data}
  localparam int PKT_FRAME_W = 40;  // Packetized link frame
  localparam int RAW_FRAME_W = 28;  // Raw link frame
  localparam int FIFO_DEPTH  = 16;  // Output buffer words
  // ==========================================
  // Register offsets
  localparam logic [7:0] REG_PORT_CFG = 8'h6D;
  localparam logic [7:0] REG_RAW_DT   = 8'h70;
  localparam logic [7:0] REG_VC_REMAP = 8'h71;
  localparam logic [7:0] REG_STATUS   = 8'h72;
  localparam logic [7:0] REG_OUT_CFG  = 8'h73;
  // Config fields
  localparam int CFG_RAW8_EN  = 2;  // Raw8 carried in 10-bit mode
  localparam int CFG_RAW8_MSB = 3;  // Raw8 sits on upper bits
  localparam int CFG_VC_LSB   = 4;  // Raw virtual channel [5:4]
  localparam int CFG_PCLK1X   = 6;  // Pixel clock 1x in non-sync mode
  // Status fields
  localparam int ST_SYNC = 0;
  localparam int ST_DONE = 1;
  localparam int ST_FERR = 2;
  localparam int ST_OVF  = 3;
  localparam int ST_STRAP_LSB = 4;
  // Reset values
  localparam logic [7:0] CFG_RST     = 8'h00;
  localparam logic [5:0] DT_RST      = 6'h00;
  localparam logic [7:0] REMAP_RST   = 8'hE4;  // Identity map
  localparam logic [7:0] OUT_CFG_RST = 8'h06;  // Four lanes
  // Packetized frame fields
  localparam int PF_KIND_LSB = 38;
  localparam int PF_VC_LSB   = 36;
  localparam int PF_DT_LSB   = 30;
  localparam int PF_DATA_LSB = 18;
  // Output word kinds
  localparam logic [1:0] KIND_FS  = 2'h0;
  localparam logic [1:0] KIND_FE  = 2'h1;
  localparam logic [1:0] KIND_LE  = 2'h2;
  localparam logic [1:0] KIND_PIX = 2'h3;
  // Input modes, codes match the strap numbers
  typedef enum logic [1:0] {MODE_PKT, MODE_RAW12LF, MODE_RAW12HF, MODE_RAW10} dpl_mode_t;
  localparam logic [2:0] STRAP_SYNC_PKT = 3'h4;
  // ==========================================
  // Rates
  localparam logic [7:0] SYNC_LINE_MULT  = 8'hA0;  // 160x
  localparam logic [2:0] SYNC_PCLK_MULT  = 3'h4;
  localparam logic [2:0] SYNC_BC_MULT    = 3'h2;
  localparam logic [7:0] NSYNC_LINE_MULT = 8'h50;  // 80x
  localparam int NSYNC_BC_MBPS  = 10;
  localparam int MAX_LINE_MBPS  = 4160;
  localparam int MAX_LANE_MBPS  = 1662;
  localparam int R12HF_MIN_KHZ  = 37500;
  localparam int R12HF_MAX_KHZ  = 100000;
  localparam int R10_MIN_KHZ    = 50000;
  localparam int R10_MAX_KHZ    = 100000;
  localparam int R12LF_MIN_KHZ  = 25000;
  localparam int R12LF_MAX_KHZ  = 50000;
  localparam int SYNC_GAP_PCLK  = 10;
  // Timing
  localparam int CLK_PERIOD_PS  = 25000;
  localparam int STRAP_WAIT_NS  = 1000000;
  localparam int STRAP_WAIT_CYC = (STRAP_WAIT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
endpackage : dpl_pkg

// ---- src/dpl_stream_if.sv ----
// Valid/ready word stream between the block's own modules
interface dpl_stream_if #(parameter int W = 22);
  logic         valid;  // Word offered
  logic         ready;  // Word taken
  logic [W-1:0] data;   // Word
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : dpl_stream_if

// ---- verification/dpl_cam_src.sv ----
// Behavioural camera pixel source for one raw parallel port
module dpl_cam_src (
  input  wire logic        go,
  input  wire logic        wide,
  input  wire logic [11:0] px0,
  input  wire logic [11:0] px1,
  output logic             pclk,
  output logic             hs,
  output logic             vs,
  output logic      [11:0] d
);
  timeunit 1ns;
  timeprecision 100ps;
  // One pixel period; the clock stands still between frames
  task automatic step();
    #100 pclk = 1'b1;
    #100 pclk = 1'b0;
  endtask : step
  initial {pclk, hs, vs, d} = 15'h0000;
  // wide frames keep sync toggles ten pixel clocks apart
  always @(posedge go) begin
    vs = 1'b1; repeat (wide ? 10 : 1) step();
    hs = 1'b1; d = px0; step();
    d = px1; repeat (wide ? 10 : 1) step();
    hs = 1'b0; d = ~px1; repeat (wide ? 10 : 1) step();
    vs = 1'b0; step();
  end
endmodule : dpl_cam_src

// ---- verification/dpl_mode_ctrl_test.sv ----
// Self-checking bench for the dual-port mode control block
module dpl_mode_ctrl_test;
  timeunit 1ns;
  timeprecision 100ps;
  import dpl_pkg::*;
  logic ref_clk, sys_rst, pdn, out_ready, out_valid, reg_wr, reg_rd, reg_port, csm, orp, go, wd;
  logic [2:0] strap;
  logic [1:0] pkv, pkr, ol;
  logic [1:0][39:0] pkf;
  logic [1:0][2:0] pm;
  logic [7:0] ra, rw, rr, lm;
  logic [11:0] px0, px1, sd;
  logic [21:0] ow;
  wire sc, sh, sv;
  logic [31:0] seed = 32'hD2393EBC;
  int error_cnt = 0, samples_checked = 0;
  logic [43:0] q[$]; // Expected {mask, word}
  dpl_mode_ctrl #(.STRAP_WAIT_CYC(20)) uut (.ref_clk(ref_clk), .sys_rst(sys_rst), .power_down_n_pin(pdn),
    .mode_strap(strap), .link_pixel_clock({sc, 1'b0}), .pix_hsync({sh, 1'b0}), .pix_vsync({sv, 1'b0}),
    .pix_data({sd, 12'h000}), .pk_valid(pkv), .pk_frame(pkf), .pk_ready(pkr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_port(reg_port), .reg_addr(ra), .reg_wdata(rw), .reg_rdata(rr), .out_ready(out_ready),
    .out_valid(out_valid), .out_word(ow), .clk_sync_mode(csm), .line_mult(lm), .pclk_mult(pm),
    .out_lanes(ol), .out_replicate(orp));
  dpl_cam_src src (.go(go), .wide(wd), .px0(px0), .px1(px1), .pclk(sc), .hs(sh), .vs(sv), .d(sd));
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13; seed ^= seed >> 17; seed ^= seed << 5;
    return seed;
  endfunction : rnd
  task wrap_up();
    if (error_cnt == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : wrap_up
  task automatic chk(input string n, input logic [21:0] e, input logic [21:0] s);
    samples_checked++;
    if (s !== e) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic fail(input string n);
    chk(n, 22'h1, 22'h0);
    wrap_up();
  endtask : fail
  // Register access: write, or read and compare
  task automatic rg(input bit w, input bit p, input logic [7:0] a, input logic [7:0] dv, input logic [7:0] e);
    @(posedge ref_clk); reg_wr <= w; reg_rd <= !w; reg_port <= p; ra <= a; rw <= dv;
    @(posedge ref_clk); reg_wr <= 1'b0; reg_rd <= 1'b0;
    @(posedge ref_clk); #1;
    if (!w) chk("reg_rdata", 22'(e), 22'(rr));
  endtask : rg
  // Offer one frame on port 0, hold until taken
  task automatic frame(input logic [1:0] k, input logic [5:0] dt, input bit bad);
    logic [39:0] f;
    int i;
    f = {k, k, dt, 12'(rnd()), 18'h00000};
    f[0] = ^f[39:1] ^ bad;
    // remap model of the written map 8'hE6
    if (!bad) q.push_back({22'h3FFFFF, k, 2'(8'hE6 >> {k, 1'b0}), dt, f[29:18]});
    @(posedge ref_clk); pkv[0] <= 1'b1; pkf[0] <= f;
    i = 0;
    do begin @(posedge ref_clk); i++; end while (pkr[0] !== 1'b1 && i < 200);
    pkv[0] <= 1'b0;
    if (i >= 200) fail("pk_ready");
  endtask : frame
  task automatic drain();
    for (int i = 0; i < 3000 && q.size() > 0; i++) @(posedge ref_clk);
    if (q.size() > 0) fail("drain");
  endtask : drain
  task automatic rx(input logic [1:0] k, input logic [11:0] dv, input bit p);
    q.push_back({p ? 22'h3FFFFF : 22'h3FF000, k, 2'd1, 6'h2C, p ? dv : 12'h000});
  endtask : rx
  always @(posedge ref_clk) begin
    out_ready <= rnd() % 4 != 0;
    if (out_valid === 1'b1 && out_ready === 1'b1) begin
      if (q.size() == 0) chk("extra word", ~ow, ow);
      else begin
        chk("out_word", q[0][21:0], ow & q[0][43:22]);
        void'(q.pop_front());
      end
    end
  end
  initial begin
    sys_rst = 1; pdn = 0; strap = 4; pkv = 0; pkf = 0; reg_wr = 0; reg_rd = 0; reg_port = 0;
    ra = 0; rw = 0; out_ready = 0; go = 0; wd = 0; px0 = 12'(rnd()); px1 = 12'(rnd());
    repeat (2) @(posedge ref_clk);
    sys_rst <= 1'b0;
    rg(0, 0, REG_PORT_CFG, 0, CFG_RST);
    rg(0, 1, REG_VC_REMAP, 0, REMAP_RST);
    rg(0, 0, REG_OUT_CFG, 0, OUT_CFG_RST);
    rg(0, 0, 8'h80, 0, 8'h00);
    chk("out_lanes", 22'h6, 22'({ol, orp}));
    pdn <= 1'b1;
    repeat (10) @(posedge ref_clk);
    chk("clk_sync_mode", 22'h0, 22'(csm));
    repeat (50) @(posedge ref_clk);
    chk("line_mult", 22'hA0, 22'(lm));
    chk("pclk_mult", 22'h24, 22'(pm));
    rg(1, 0, REG_VC_REMAP, 8'hE6, 0);
    for (int n = 0; n < 4; n++) frame(2'(n), 6'(n * 7 + 1), 0);
    frame(2'd3, 6'h2A, 1);
    frame(2'd3, 6'h2B, 0);
    drain();
    rg(0, 0, REG_STATUS, 0, 8'h47);
    rg(1, 0, REG_STATUS, 8'h04, 0);
    rg(0, 0, REG_STATUS, 0, 8'h43);
    rg(1, 0, REG_OUT_CFG, 8'h07, 0);
    chk("out_lanes", 22'h3, 22'({ol, orp}));
    rg(1, 1, REG_PORT_CFG, 8'h11, 0);
    rg(1, 1, REG_RAW_DT, 8'h2C, 0);
    rx(KIND_FS, 0, 0); rx(KIND_PIX, px0, 1); rx(KIND_PIX, px1, 1); rx(KIND_LE, 0, 0); rx(KIND_FE, 0, 0);
    go <= 1'b1;
    drain();
    rg(0, 1, REG_PORT_CFG, 0, 8'h11);
    go <= 1'b0;
    wd <= 1'b1;
    rg(1, 1, REG_PORT_CFG, 8'h1F, 0);
    rx(KIND_FS, 0, 0); rx(KIND_PIX, {4'h0, px0[9:2]}, 1);
    repeat (10) rx(KIND_PIX, {4'h0, px1[9:2]}, 1);
    rx(KIND_LE, 0, 0); rx(KIND_FE, 0, 0);
    go <= 1'b1;
    drain();
    rg(0, 1, REG_STATUS, 0, 8'h43);
    rg(1, 0, REG_PORT_CFG, 8'h40, 0);
    @(posedge ref_clk);
    pdn <= 1'b0;
    strap <= 3'h0;
    repeat (10) @(posedge ref_clk);
    pdn <= 1'b1;
    repeat (60) @(posedge ref_clk);
    chk("rates", 22'h1411, 22'({csm, lm, pm}));
    wrap_up();
  end
endmodule : dpl_mode_ctrl_test
